// [src/rot_sub_skip_datapath.v]
// execution datapath for rotates, subtracts, skips, byte and bit set, swap
// assumes the sequencer presents the memory byte with the op and writes back
// inputs are synchronous to core_clk; one op is presented per opStart pulse
`timescale 1ns/1ps
`include "rot_sub_skip_defs.vh"

module rot_sub_skip_datapath (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // operation request from the sequencer
  input wire opStart,
  input wire [4:0] opCode,
  input wire [2:0] bitSel,
  input wire [7:0] immData,
  input wire [7:0] memRdData,
  // results to sequencer and data memory
  output reg opDone,
  output reg memWrEn,
  output reg [7:0] memWrData,
  output reg skipNext,
  output reg dummyCycle,
  output reg busy,
  // architectural state
  output reg [7:0] workRegister,
  output reg carryFlag,
  output reg halfCarryFlag,
  output reg zeroFlag,
  output reg signedWrapFlag,
  output reg signedResultFlag,
  output reg combinedZeroFlag,
  // register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData
);

  localparam ST_IDLE = 1'b0;
  localparam ST_DUMMY = 1'b1;

  // flag reset pattern as a vector, so each flag can pick its own bit
  localparam [5:0] FLAGS_AT_RESET = `RESET_FLAGS;

  reg state;
  reg lastSkip;

  // a request while the dummy cycle is pending is dropped
  wire take = opStart && (state == ST_IDLE);

  // subtract operands
  reg [7:0] subB;
  reg subBorrowIn;
  reg subWithBorrow;
  reg [8:0] subFull;
  reg [4:0] subLow;
  reg [7:0] subRes;
  // subtract flag results; half carry from the nibble difference, the rest from the full one
  reg subCarry;
  reg subHalf;
  reg subZero;
  reg subWrap;
  reg subSign;
  reg subCombZero;

  // combinational results of the requested op
  reg [7:0] next_mem;
  reg next_memWe;
  reg [7:0] next_work;
  reg next_workWe;
  reg next_carry;
  reg next_carryWe;
  reg next_subFlags;
  reg next_skipType;
  reg next_skip;
  reg [7:0] memInc;
  reg [7:0] memDec;
  reg [7:0] bitMask;
  // register read words assembled from the field positions
  reg [7:0] flagsWord;
  reg [7:0] statusWord;

  // subtract path shared by all six subtract forms
  always @* begin
    subWithBorrow = (opCode == `OP_MINUS_WITH_BORROW_WORK) ||
                    (opCode == `OP_MINUS_WITH_BORROW_IMM) ||
                    (opCode == `OP_MINUS_WITH_BORROW_MEM);
    subB = ((opCode == `OP_MINUS_WITH_BORROW_IMM) ||
            (opCode == `OP_MINUS_IMM)) ? immData : memRdData;
    // inverted carry is the borrow in
    subBorrowIn = subWithBorrow & ~carryFlag;
    subFull = {1'b0, workRegister} - {1'b0, subB} - {8'h00, subBorrowIn};
    subLow = {1'b0, workRegister[3:0]} - {1'b0, subB[3:0]} -
             {4'h0, subBorrowIn};
    subRes = subFull[7:0];
    // no borrow out of bit 7 means the difference is zero or positive
    subCarry = ~subFull[8];
    // no borrow out of the low nibble
    subHalf = ~subLow[4];
    subZero = (subRes == 8'h00);
    // operand signs differ and the result sign left the work sign
    subWrap = (workRegister[7] ^ subB[7]) & (subRes[7] ^ workRegister[7]);
    // true sign of the result, corrected for wrap
    subSign = subRes[7] ^ subWrap;
    // chained multi-byte zero: borrow forms keep the earlier byte's zero
    subCombZero = subZero & (~subWithBorrow | combinedZeroFlag);
  end

  // per-op result selection
  always @* begin
    memInc = memRdData + 8'h01;
    memDec = memRdData - 8'h01;
    bitMask = 8'h01 << bitSel;
    // defaults: nothing written, nothing skipped, flags kept
    next_mem = memRdData;
    next_memWe = 1'b0;
    next_work = workRegister;
    next_workWe = 1'b0;
    next_carry = carryFlag;
    next_carryWe = 1'b0;
    next_subFlags = 1'b0;
    next_skipType = 1'b0;
    next_skip = 1'b0;
    case (opCode)
      // plain rotates: carry is neither read nor written
      `OP_ROT_LEFT_TO_WORK: begin
        next_work = {memRdData[6:0], memRdData[7]};
        next_workWe = 1'b1;
      end
      // nine-bit rotates take old carry in and the bit shifted out becomes carry; the plain right rotates here leave carry alone
      `OP_ROT_LEFT_THRU_FLAG_MEM: begin
        next_mem = {memRdData[6:0], carryFlag};
        next_memWe = 1'b1;
        next_carry = memRdData[7];
        next_carryWe = 1'b1;
      end
      `OP_ROT_LEFT_THRU_FLAG_WORK: begin
        next_work = {memRdData[6:0], carryFlag};
        next_workWe = 1'b1;
        next_carry = memRdData[7];
        next_carryWe = 1'b1;
      end
      `OP_ROT_RIGHT_MEM: begin
        next_mem = {memRdData[0], memRdData[7:1]};
        next_memWe = 1'b1;
      end
      `OP_ROT_RIGHT_TO_WORK: begin
        next_work = {memRdData[0], memRdData[7:1]};
        next_workWe = 1'b1;
      end
      `OP_ROT_RIGHT_THRU_FLAG_MEM: begin
        next_mem = {carryFlag, memRdData[7:1]};
        next_memWe = 1'b1;
        next_carry = memRdData[0];
        next_carryWe = 1'b1;
      end
      `OP_ROT_RIGHT_THRU_FLAG_WORK: begin
        next_work = {carryFlag, memRdData[7:1]};
        next_workWe = 1'b1;
        next_carry = memRdData[0];
        next_carryWe = 1'b1;
      end
      // work-destination subtracts; immediate forms take immData instead
      `OP_MINUS_WITH_BORROW_WORK,
      `OP_MINUS_WITH_BORROW_IMM,
      `OP_MINUS_WORK,
      `OP_MINUS_IMM: begin
        next_work = subRes;
        next_workWe = 1'b1;
        next_subFlags = 1'b1;
      end
      // memory-destination subtracts leave the work register as it was
      `OP_MINUS_WITH_BORROW_MEM,
      `OP_MINUS_INTO_MEM: begin
        next_mem = subRes;
        next_memWe = 1'b1;
        next_subFlags = 1'b1;
      end
      // counting skips: the new value decides the skip, flags stay put
      `OP_DEC_SKIP_IF_ZERO: begin
        next_mem = memDec;
        next_memWe = 1'b1;
        next_skipType = 1'b1;
        next_skip = (memDec == 8'h00);
      end
      `OP_DEC_SKIP_IF_ZERO_WORK: begin
        next_work = memDec;
        next_workWe = 1'b1;
        next_skipType = 1'b1;
        next_skip = (memDec == 8'h00);
      end
      `OP_INC_SKIP_IF_ZERO: begin
        next_mem = memInc;
        next_memWe = 1'b1;
        next_skipType = 1'b1;
        next_skip = (memInc == 8'h00);
      end
      `OP_INC_SKIP_IF_ZERO_WORK: begin
        next_work = memInc;
        next_workWe = 1'b1;
        next_skipType = 1'b1;
        next_skip = (memInc == 8'h00);
      end
      // pure test: no write-back, the selected bit decides the skip
      `OP_SKIP_IF_BIT_NONZERO: begin
        next_skipType = 1'b1;
        next_skip = |(memRdData & bitMask);
      end
      `OP_SKIP_IF_NONZERO: begin
        // same value goes back, so the write is harmless
        next_memWe = 1'b1;
        next_skipType = 1'b1;
        next_skip = (memRdData != 8'h00);
      end
      // set and swap ops write memory only
      `OP_SET_BYTE: begin
        next_mem = `ALL_ONES;
        next_memWe = 1'b1;
      end
      `OP_SET_BIT: begin
        next_mem = memRdData | bitMask;
        next_memWe = 1'b1;
      end
      `OP_SWAP_NIBBLES: begin
        next_mem = {memRdData[3:0], memRdData[7:4]};
        next_memWe = 1'b1;
      end
      default: begin
        // unknown code: answered with opDone, write data reloaded with the memory byte, nothing else moves
        next_mem = memRdData;
      end
    endcase
  end

  // sequencing: one result cycle, skip ops add a dummy cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      opDone <= 1'b0;
      memWrEn <= 1'b0;
      memWrData <= 8'h00;
      skipNext <= 1'b0;
      dummyCycle <= 1'b0;
      lastSkip <= 1'b0;
    end else begin
      opDone <= take;
      memWrEn <= take & next_memWe;
      skipNext <= take & next_skip;
      dummyCycle <= 1'b0;
      // write data holds between ops so a slow memory can still latch it
      if (take) begin
        memWrData <= next_mem;
      end
      // only skip-type ops leave idle; every other op answers in one cycle
      case (state)
        ST_IDLE: begin
          if (take && next_skipType) begin
            state <= ST_DUMMY;
            busy <= 1'b1;
            lastSkip <= next_skip;
          end
        end
        ST_DUMMY: begin
          // next fetch is discarded here whether or not it is skipped
          dummyCycle <= 1'b1;
          busy <= 1'b0;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // work register; an op in the same cycle wins over a software write
  // the losing write is dropped rather than merged, to keep results whole
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      workRegister <= `RESET_WORK;
    end else if (take && next_workWe) begin
      workRegister <= next_work;
    end else if (regWrite && (regAddr == `ADDR_WORK)) begin
      workRegister <= regWrData;
    end
  end

  // status flags; skip, set and swap ops leave them alone
  // any op that moves a flag blocks the whole software write, so no torn set
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      carryFlag <= FLAGS_AT_RESET[`FLAG_CARRY];
      halfCarryFlag <= FLAGS_AT_RESET[`FLAG_HALF_CARRY];
      zeroFlag <= FLAGS_AT_RESET[`FLAG_ZERO];
      signedWrapFlag <= FLAGS_AT_RESET[`FLAG_SIGNED_WRAP];
      signedResultFlag <= FLAGS_AT_RESET[`FLAG_SIGNED_RESULT];
      combinedZeroFlag <= FLAGS_AT_RESET[`FLAG_COMBINED_ZERO];
    end else if (take && next_subFlags) begin
      // exactly the six subtract flags move here
      carryFlag <= subCarry;
      halfCarryFlag <= subHalf;
      zeroFlag <= subZero;
      signedWrapFlag <= subWrap;
      signedResultFlag <= subSign;
      combinedZeroFlag <= subCombZero;
    end else if (take && next_carryWe) begin
      carryFlag <= next_carry;
    end else if (regWrite && (regAddr == `ADDR_FLAGS)) begin
      carryFlag <= regWrData[`FLAG_CARRY];
      halfCarryFlag <= regWrData[`FLAG_HALF_CARRY];
      zeroFlag <= regWrData[`FLAG_ZERO];
      signedWrapFlag <= regWrData[`FLAG_SIGNED_WRAP];
      signedResultFlag <= regWrData[`FLAG_SIGNED_RESULT];
      combinedZeroFlag <= regWrData[`FLAG_COMBINED_ZERO];
    end
  end

  // flag and status words laid out by the field positions, spare bits zero
  always @* begin
    flagsWord = 8'h00;
    flagsWord[`FLAG_CARRY] = carryFlag;
    flagsWord[`FLAG_HALF_CARRY] = halfCarryFlag;
    flagsWord[`FLAG_ZERO] = zeroFlag;
    flagsWord[`FLAG_SIGNED_WRAP] = signedWrapFlag;
    flagsWord[`FLAG_SIGNED_RESULT] = signedResultFlag;
    flagsWord[`FLAG_COMBINED_ZERO] = combinedZeroFlag;
    statusWord = 8'h00;
    statusWord[`STAT_BUSY] = busy;
    statusWord[`STAT_LAST_SKIP] = lastSkip;
  end

  // read port: data one cycle after the strobe, zero otherwise
  // an unmapped address reads as zero, like an idle cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `ADDR_WORK: regRdData <= workRegister;
        `ADDR_FLAGS: regRdData <= flagsWord;
        `ADDR_STATUS: regRdData <= statusWord;
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule // rot_sub_skip_datapath

// [src/rot_sub_skip_defs.vh]
// constants for the rotate, subtract, skip and set datapath
// assumes inclusion by bare name from the datapath module
`ifndef ROT_SUB_SKIP_DEFS_VH
`define ROT_SUB_SKIP_DEFS_VH

// operation codes on opCode
`define OP_ROT_LEFT_TO_WORK 5'h00
`define OP_ROT_LEFT_THRU_FLAG_MEM 5'h01
`define OP_ROT_LEFT_THRU_FLAG_WORK 5'h02
`define OP_ROT_RIGHT_MEM 5'h03
`define OP_ROT_RIGHT_TO_WORK 5'h04
`define OP_ROT_RIGHT_THRU_FLAG_MEM 5'h05
`define OP_ROT_RIGHT_THRU_FLAG_WORK 5'h06
`define OP_MINUS_WITH_BORROW_WORK 5'h07
`define OP_MINUS_WITH_BORROW_IMM 5'h08
`define OP_MINUS_WITH_BORROW_MEM 5'h09
`define OP_MINUS_WORK 5'h0a
`define OP_MINUS_IMM 5'h0b
`define OP_MINUS_INTO_MEM 5'h0c
`define OP_DEC_SKIP_IF_ZERO 5'h0d
`define OP_DEC_SKIP_IF_ZERO_WORK 5'h0e
`define OP_INC_SKIP_IF_ZERO 5'h0f
`define OP_INC_SKIP_IF_ZERO_WORK 5'h10
`define OP_SKIP_IF_BIT_NONZERO 5'h11
`define OP_SKIP_IF_NONZERO 5'h12
`define OP_SET_BYTE 5'h13
`define OP_SET_BIT 5'h14
`define OP_SWAP_NIBBLES 5'h15

// register byte addresses
`define ADDR_WORK 8'h00
`define ADDR_FLAGS 8'h04
`define ADDR_STATUS 8'h08

// flag bit positions in the flags register
`define FLAG_CARRY 0
`define FLAG_HALF_CARRY 1
`define FLAG_ZERO 2
`define FLAG_SIGNED_WRAP 3
`define FLAG_SIGNED_RESULT 4
`define FLAG_COMBINED_ZERO 5

// status register bit positions
`define STAT_BUSY 0
`define STAT_LAST_SKIP 1

// reset values and the byte-set pattern
`define RESET_WORK 8'h00
`define RESET_FLAGS 6'h00
`define ALL_ONES 8'hff

`endif

// [test/rot_sub_skip_monitor.sv]
// checker on the datapath ports: op timing, skip walk, result bytes
// assumes one op per taken opStart and a sequencer that keeps ORDER
`timescale 1ns/1ps
`include "rot_sub_skip_defs.vh"
module rot_sub_skip_monitor (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // op request
  input wire opStart,
  input wire [4:0] opCode,
  input wire [7:0] memRdData,
  input wire regWrite,
  // results
  input wire opDone,
  input wire memWrEn,
  input wire [7:0] memWrData,
  input wire skipNext,
  input wire dummyCycle,
  input wire busy,
  input wire [7:0] workRegister,
  input wire carryFlag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // taken request and skip-type decode
  wire taken = opStart && !busy;
  wire isSkip = opCode >= `OP_DEC_SKIP_IF_ZERO && opCode <= `OP_SKIP_IF_NONZERO;
  reg [7:0] lastMem;
  reg [7:0] lastWork;
  // operands as seen at the taking edge, so no slice of a past value is needed
  always @(posedge core_clk) begin
    lastMem <= memRdData;
    lastWork <= workRegister;
  end
  // skip walk: answer with busy, then the dummy cycle frees the port
  sequence skip_tail;
    opDone && busy ##1 dummyCycle && !busy;
  endsequence
  single_cycle_op_a: assert property (taken && !isSkip |=> opDone && !busy && !dummyCycle ##1 !dummyCycle)
    else $error("plain op did not finish in one cycle");
  skip_two_cycle_a: assert property (taken && isSkip |=> skip_tail)
    else $error("skip op walk wrong");
  skip_flag_hold_a: assert property (taken && isSkip && !regWrite |=> $stable(carryFlag))
    else $error("skip op changed carry");
  rot_left_work_a: assert property (taken && opCode == `OP_ROT_LEFT_TO_WORK |=>
    !memWrEn && workRegister == {lastMem[6:0], lastMem[7]})
    else $error("left rotate to work wrong");
  rot_right_mem_a: assert property (taken && opCode == `OP_ROT_RIGHT_MEM |=>
    memWrEn && memWrData == {lastMem[0], lastMem[7:1]})
    else $error("right rotate of memory wrong");
  set_byte_a: assert property (taken && opCode == `OP_SET_BYTE |=> memWrEn && memWrData == 8'hff)
    else $error("byte set wrong");
  swap_nibble_a: assert property (taken && opCode == `OP_SWAP_NIBBLES |=>
    memWrEn && memWrData == {lastMem[3:0], lastMem[7:4]})
    else $error("nibble swap wrong");
  sub_carry_a: assert property (taken && opCode == `OP_MINUS_WORK |=> carryFlag == (lastWork >= lastMem))
    else $error("subtract carry wrong");
  dec_skip_a: assert property (taken && opCode == `OP_DEC_SKIP_IF_ZERO |=>
    memWrEn && memWrData == lastMem - 8'h01 && skipNext == (lastMem == 8'h01))
    else $error("decrement skip wrong");
endmodule // rot_sub_skip_monitor
bind rot_sub_skip_datapath rot_sub_skip_monitor mon (.core_clk, .rst_n, .opStart, .opCode, .memRdData,
  .regWrite, .opDone, .memWrEn, .memWrData, .skipNext, .dummyCycle, .busy, .workRegister, .carryFlag);

// [test/seq_mem_model.sv]
// data memory byte on the sequencer side of the datapath
// assumes the bench preloads the operand byte before each op
`timescale 1ns/1ps
module seq_mem_model (
  // clock
  input wire core_clk,
  // bench preload
  input wire loadEn,
  input wire [7:0] loadData,
  // write-back from the datapath
  input wire memWrEn,
  input wire [7:0] memWrData,
  output reg [7:0] memByte
);
  // preload wins; the byte only changes on a real write-back
  always @(posedge core_clk) begin
    if (loadEn) begin
      memByte <= loadData;
    end else if (memWrEn) begin
      memByte <= memWrData;
    end
  end
endmodule // seq_mem_model

// [test/rot_sub_skip_datapath_tb.sv]
// self-checking bench for the rotate, subtract, skip and set datapath
// assumes the memory model feeds memRdData and takes write-backs
`timescale 1ns/1ps
module rot_sub_skip_datapath_tb;
  reg core_clk, rst_n, opStart, regWrite, regRead, loadEn;
  reg [4:0] opCode;
  reg [2:0] bitSel;
  reg [7:0] immData, regAddr, regWrData, loadData;
  wire opDone, memWrEn, skipNext, dummyCycle, busy, carryFlag, zeroFlag;
  wire [7:0] memWrData, workRegister, regRdData, memByte;
  integer mismatches, comparisons;
  // design and memory side
  rot_sub_skip_datapath dut (.core_clk, .rst_n, .opStart, .opCode, .bitSel, .immData,
    .memRdData(memByte), .opDone, .memWrEn, .memWrData, .skipNext, .dummyCycle, .busy,
    .workRegister, .carryFlag, .halfCarryFlag(), .zeroFlag, .signedWrapFlag(),
    .signedResultFlag(), .combinedZeroFlag(), .regAddr, .regWrData, .regWrite, .regRead, .regRdData);
  seq_mem_model mem (.core_clk, .loadEn, .loadData, .memWrEn, .memWrData, .memByte);
  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task chk8(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk1(input got, input exp);
    begin
      chk8({7'h00, got}, {7'h00, exp});
    end
  endtask
  // register port: one-cycle strobes, read data only in the next cycle
  task regWr(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
    end
  endtask
  task regRd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1;
      chk8(regRdData, exp);
    end
  endtask
  // one op: preload memory, pulse opStart, check answer then write-back
  task op(input [4:0] c, input [7:0] m, input [7:0] x, input [7:0] w, input [7:0] mb, input s, input cy);
    begin
      @(posedge core_clk);
      loadEn <= 1'b1;
      loadData <= m;
      @(posedge core_clk);
      loadEn <= 1'b0;
      opStart <= 1'b1;
      opCode <= c;
      bitSel <= x[2:0];
      immData <= x;
      @(posedge core_clk);
      opStart <= 1'b0;
      #1;
      chk1(opDone, 1'b1);
      chk1(skipNext, s);
      chk8(workRegister, w);
      chk1(carryFlag, cy);
      @(posedge core_clk);
      #1;
      chk1(dummyCycle, c >= 5'h0d && c <= 5'h12);
      chk8(memByte, mb);
    end
  endtask
  task end_sim;
    begin
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  // a hang is cut well past the roughly 132 cycles the tests need
  initial begin
    #20000;
    mismatches = mismatches + 1;
    end_sim;
  end
  // main sequence
  initial begin
    {rst_n, opStart, regWrite, regRead, loadEn} = 5'h00;
    {opCode, bitSel, immData, regAddr, regWrData, loadData} = 40'h00_0000_0000;
    mismatches = 0;
    comparisons = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    regWr(8'h04, 8'h01);
    regWr(8'h00, 8'h5a);
    op(5'h00, 8'h81, 8'h00, 8'h03, 8'h81, 1'b0, 1'b1);
    op(5'h01, 8'h40, 8'h00, 8'h03, 8'h81, 1'b0, 1'b0);
    op(5'h02, 8'h80, 8'h00, 8'h00, 8'h80, 1'b0, 1'b1);
    op(5'h03, 8'h01, 8'h00, 8'h00, 8'h80, 1'b0, 1'b1);
    op(5'h04, 8'h02, 8'h00, 8'h01, 8'h02, 1'b0, 1'b1);
    op(5'h05, 8'h02, 8'h00, 8'h01, 8'h81, 1'b0, 1'b0);
    op(5'h06, 8'h01, 8'h00, 8'h00, 8'h01, 1'b0, 1'b1);
    regWr(8'h00, 8'h10);
    op(5'h0a, 8'h20, 8'h00, 8'hf0, 8'h20, 1'b0, 1'b0);
    op(5'h0b, 8'h00, 8'hf0, 8'h00, 8'h00, 1'b0, 1'b1);
    regRd(8'h04, 8'h27);
    regWr(8'h04, 8'h00);
    regWr(8'h00, 8'h05);
    op(5'h07, 8'h02, 8'h00, 8'h02, 8'h02, 1'b0, 1'b1);
    op(5'h08, 8'h00, 8'h02, 8'h00, 8'h00, 1'b0, 1'b1);
    op(5'h09, 8'h01, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0);
    op(5'h0c, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
    op(5'h0d, 8'h01, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
    regRd(8'h08, 8'h02);
    op(5'h0d, 8'h00, 8'h00, 8'h00, 8'hff, 1'b0, 1'b1);
    op(5'h0e, 8'h01, 8'h00, 8'h00, 8'h01, 1'b1, 1'b1);
    op(5'h0e, 8'h03, 8'h00, 8'h02, 8'h03, 1'b0, 1'b1);
    op(5'h0f, 8'hff, 8'h00, 8'h02, 8'h00, 1'b1, 1'b1);
    op(5'h10, 8'hff, 8'h00, 8'h00, 8'hff, 1'b1, 1'b1);
    op(5'h10, 8'h00, 8'h00, 8'h01, 8'h00, 1'b0, 1'b1);
    op(5'h11, 8'h80, 8'h07, 8'h01, 8'h80, 1'b1, 1'b1);
    op(5'h11, 8'h7f, 8'h07, 8'h01, 8'h7f, 1'b0, 1'b1);
    op(5'h12, 8'h05, 8'h00, 8'h01, 8'h05, 1'b1, 1'b1);
    op(5'h12, 8'h00, 8'h00, 8'h01, 8'h00, 1'b0, 1'b1);
    op(5'h13, 8'h12, 8'h00, 8'h01, 8'hff, 1'b0, 1'b1);
    op(5'h14, 8'h00, 8'h00, 8'h01, 8'h01, 1'b0, 1'b1);
    op(5'h14, 8'h7f, 8'h07, 8'h01, 8'hff, 1'b0, 1'b1);
    op(5'h15, 8'ha5, 8'h00, 8'h01, 8'h5a, 1'b0, 1'b1);
    regRd(8'h0c, 8'h00);
    end_sim;
  end
endmodule // rot_sub_skip_datapath_tb
